// ==== rtl/ebcs_top.v ====
// External bus and chip-select pin engine: asynchronous and burst-read accesses.
// Assumes requests come from logic on ref_clk_in; all pin inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ebcs_defines.vh"

module ebcs_top #(
    parameter integer ASYNC_WAIT = `EBCS_ASYNC_WAIT_CYC,
    parameter integer ACK_TIMEOUT = `EBCS_ACK_TIMEOUT_CYC,
    parameter integer FIRST_LAT = `EBCS_FIRST_LAT_BCLK,
    parameter integer BCLK_HALF = `EBCS_BCLK_HALF_CYC
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire req_valid_in,
    output reg req_ready_out,
    input wire req_write_in,
    input wire [`EBCS_ADDR_W-1:0] req_addr_in,
    input wire [`EBCS_DATA_W-1:0] req_wdata_in,
    input wire [3:0] req_be_in,
    input wire [2:0] req_cs_in,
    input wire [3:0] req_burst_len_in,
    output reg rsp_valid_out,
    output reg [`EBCS_DATA_W-1:0] rsp_rdata_out,
    output reg rsp_last_out,
    input wire [`EBCS_NUM_CS-1:0] cs_burst_mode_in,
    input wire function_mux_control_in,
    input wire ack_mode_in,
    input wire [1:0] sdram_chip_select_n_in,
    output reg [`EBCS_ADDR_W-1:0] address_out,
    output reg [`EBCS_DATA_W-1:0] data_out,
    output reg data_oe_out,
    input wire [`EBCS_DATA_W-1:0] data_in,
    output reg byte_strobe_lane3_msb_n_out,
    output reg byte_strobe_lane2_n_out,
    output reg byte_strobe_lane1_n_out,
    output reg byte_strobe_lane0_lsb_n_out,
    output reg output_enable_n_out,
    output reg read_write_out,
    output reg [`EBCS_NUM_CS-1:0] chip_select_n_out,
    output reg chip_select4_oe_out,
    input wire chip_select4_pin_in,
    input wire burst_restart_n_in,
    output reg load_burst_address_n_out,
    output wire burst_clock_out
);

    // ****************************************************************
    // States and helpers
    // ****************************************************************
    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_ASYNC = 4'h2;
    localparam [3:0] S_LATCH = 4'h4;
    localparam [3:0] S_BEAT = 4'h8;

    function [`EBCS_NUM_CS-1:0] cs_decode_n;
        input [2:0] idx;
        integer k;
        begin
            cs_decode_n = `EBCS_CS_IDLE;
            for (k = 0; k < `EBCS_NUM_CS; k = k + 1) begin
                if (idx == k[2:0]) begin
                    cs_decode_n[k] = 1'b0;
                end
            end
        end
    endfunction

    reg [3:0] state_q;
    reg [7:0] cnt_q;
    reg [3:0] beats_q;
    reg [`EBCS_NUM_CS-1:0] cs_int_n_q;
    reg mux_q;
    reg ack_mode_q;
    reg bclk_run_q;
    wire bclk_rise;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg [`EBCS_DATA_W-1:0] din_meta_q, din_q;
    reg ack_meta_q, ack_n_q;
    reg rst_meta_q, restart_n_q;

    always @(posedge ref_clk_in) begin
        din_meta_q <= data_in;
        din_q <= din_meta_q;
        ack_meta_q <= chip_select4_pin_in;
        ack_n_q <= ack_meta_q;
        rst_meta_q <= burst_restart_n_in;
        restart_n_q <= rst_meta_q;
    end

    // ****************************************************************
    // Burst clock
    // ****************************************************************
    ebcs_burst_clk #(
        .HALF_CYC(BCLK_HALF)
    ) u_bclk (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .run_in(bclk_run_q),
        .bclk_out(burst_clock_out),
        .rise_out(bclk_rise)
    );

    // ****************************************************************
    // Chip-select pins and their multiplexing
    // ****************************************************************
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            mux_q <= `EBCS_MUX_RESET;
            ack_mode_q <= 1'b0;
        end else begin
            // Mode changes only take effect between accesses.
            if (state_q == S_IDLE) begin
                mux_q <= function_mux_control_in;
                ack_mode_q <= ack_mode_in;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `EBCS_NUM_CS; g = g + 1) begin : g_cs
            always @(posedge ref_clk_in) begin
                if (rst_in) begin
                    chip_select_n_out[g] <= 1'b1;
                end else if ((g == 2 || g == 3) && !mux_q) begin
                    chip_select_n_out[g] <= sdram_chip_select_n_in[g % 2];
                end else if (g == 4 && ack_mode_q) begin
                    chip_select_n_out[g] <= 1'b1;
                end else begin
                    chip_select_n_out[g] <= cs_int_n_q[g];
                end
            end
        end
    endgenerate

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            chip_select4_oe_out <= 1'b1;
        end else begin
            // The pin turns around to an input while acknowledge mode is on.
            chip_select4_oe_out <= ~ack_mode_q;
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= S_IDLE;
            cnt_q <= 8'h00;
            beats_q <= 4'h0;
            cs_int_n_q <= `EBCS_CS_IDLE;
            bclk_run_q <= 1'b0;
            req_ready_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 32'h00000000;
            rsp_last_out <= 1'b0;
            address_out <= 26'h0000000;
            data_out <= 32'h00000000;
            data_oe_out <= 1'b0;
            byte_strobe_lane3_msb_n_out <= 1'b1;
            byte_strobe_lane2_n_out <= 1'b1;
            byte_strobe_lane1_n_out <= 1'b1;
            byte_strobe_lane0_lsb_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            read_write_out <= 1'b1;
            load_burst_address_n_out <= 1'b1;
        end else begin
            rsp_valid_out <= 1'b0;
            rsp_last_out <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        req_ready_out <= 1'b0;
                        address_out <= req_addr_in;
                        cs_int_n_q <= cs_decode_n(req_cs_in);
                        if (req_write_in) begin
                            read_write_out <= 1'b0;
                            data_out <= req_wdata_in;
                            data_oe_out <= 1'b1;
                            byte_strobe_lane3_msb_n_out <= ~req_be_in[3];
                            byte_strobe_lane2_n_out <= ~req_be_in[2];
                            byte_strobe_lane1_n_out <= ~req_be_in[1];
                            byte_strobe_lane0_lsb_n_out <= ~req_be_in[0];
                        end else begin
                            read_write_out <= 1'b1;
                            output_enable_n_out <= 1'b0;
                            byte_strobe_lane3_msb_n_out <= 1'b0;
                            byte_strobe_lane2_n_out <= 1'b0;
                            byte_strobe_lane1_n_out <= 1'b0;
                            byte_strobe_lane0_lsb_n_out <= 1'b0;
                        end
                        // Writes and async selects never start the burst clock.
                        if (!req_write_in && cs_burst_mode_in[req_cs_in] && req_burst_len_in != 4'h0) begin
                            load_burst_address_n_out <= 1'b0;
                            bclk_run_q <= 1'b1;
                            cnt_q <= FIRST_LAT[7:0];
                            beats_q <= req_burst_len_in;
                            state_q <= S_LATCH;
                        end else begin
                            load_burst_address_n_out <= 1'b1;
                            bclk_run_q <= 1'b0;
                            cnt_q <= ASYNC_WAIT[7:0];
                            state_q <= S_ASYNC;
                        end
                    end
                end
                S_ASYNC: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                    // In acknowledge mode the peripheral ends the access; a missing acknowledge stalls the engine.
                    if (cnt_q == 8'h00 && (!ack_mode_q || !ack_n_q)) begin
                        if (read_write_out) begin
                            rsp_valid_out <= 1'b1;
                            rsp_rdata_out <= din_q;
                        end
                        rsp_last_out <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (ack_mode_q && cnt_q == 8'h00) begin
                        cnt_q <= 8'hff - ACK_TIMEOUT[7:0];
                    end
                end
                S_LATCH: begin
                    if (!restart_n_q) begin
                        load_burst_address_n_out <= 1'b0;
                        cnt_q <= FIRST_LAT[7:0];
                    end else if (bclk_rise) begin
                        load_burst_address_n_out <= 1'b1;
                        if (cnt_q == 8'h01) begin
                            state_q <= S_BEAT;
                        end
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_BEAT: begin
                    if (!restart_n_q) begin
                        // A restart resumes at the next unread word with a fresh long first access.
                        load_burst_address_n_out <= 1'b0;
                        cnt_q <= FIRST_LAT[7:0];
                        state_q <= S_LATCH;
                    end else if (bclk_rise) begin
                        rsp_valid_out <= 1'b1;
                        rsp_rdata_out <= din_q;
                        address_out <= address_out + 26'h0000001;
                        beats_q <= beats_q - 4'h1;
                        if (beats_q == 4'h1) begin
                            rsp_last_out <= 1'b1;
                            bclk_run_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
            if (state_q != S_IDLE && state_q != 4'h0) begin
                if ((state_q == S_ASYNC && cnt_q == 8'h00 && (!ack_mode_q || !ack_n_q)) ||
                    (state_q == S_BEAT && restart_n_q && bclk_rise && beats_q == 4'h1)) begin
                    cs_int_n_q <= `EBCS_CS_IDLE;
                    req_ready_out <= 1'b1;
                    data_oe_out <= 1'b0;
                    output_enable_n_out <= 1'b1;
                    read_write_out <= 1'b1;
                    byte_strobe_lane3_msb_n_out <= 1'b1;
                    byte_strobe_lane2_n_out <= 1'b1;
                    byte_strobe_lane1_n_out <= 1'b1;
                    byte_strobe_lane0_lsb_n_out <= 1'b1;
                    load_burst_address_n_out <= 1'b1;
                end
            end
        end
    end

endmodule // ebcs_top
`default_nettype wire

// ==== rtl/ebcs_defines.vh ====
// Constants shared by the external bus and chip-select block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef EBCS_DEFINES_VH
`define EBCS_DEFINES_VH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define EBCS_ADDR_W 26
`define EBCS_DATA_W 32
`define EBCS_NUM_CS 6

// ****************************************************************
// Timing
// ****************************************************************
`define EBCS_CLK_PERIOD_NS 10
`define EBCS_ASYNC_WAIT_NS 40
`define EBCS_ASYNC_WAIT_CYC ((`EBCS_ASYNC_WAIT_NS + `EBCS_CLK_PERIOD_NS - 1) / `EBCS_CLK_PERIOD_NS)
`define EBCS_ACK_TIMEOUT_CYC 64
`define EBCS_BCLK_HALF_CYC 4
`define EBCS_FIRST_LAT_BCLK 3

// ****************************************************************
// Reset values
// ****************************************************************
`define EBCS_MUX_RESET 1'b0
`define EBCS_CS_IDLE 6'h3f

`endif

// ==== rtl/ebcs_burst_clk.v ====
// Burst clock divider for the external bus block.
// Assumes one core clock; the burst clock is a flop output, low while stopped.
`timescale 1ns/1ps
`default_nettype none
`include "ebcs_defines.vh"

module ebcs_burst_clk #(
    parameter integer HALF_CYC = `EBCS_BCLK_HALF_CYC
) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire run_in,
    output reg bclk_out,
    output reg rise_out
);

    reg [7:0] cnt_q;

    always @(posedge ref_clk_in) begin
        rise_out <= 1'b0;
        if (rst_in || !run_in) begin
            // Stopping forces the clock low at once, which cuts short a high phase already under way.
            cnt_q <= 8'h00;
            bclk_out <= 1'b0;
        end else if (cnt_q == HALF_CYC[7:0] - 8'h01) begin
            cnt_q <= 8'h00;
            bclk_out <= ~bclk_out;
            rise_out <= ~bclk_out;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule // ebcs_burst_clk
`default_nettype wire

// ==== test/ebcs_flash_model.sv ====
// Memory and peripheral model that sits on the far side of the external bus pins.
// Assumes the bench resolves the shared select-4 pin and feeds the acknowledge in.
`timescale 1ns/1ps
`default_nettype none
module ebcs_flash_model (
    input wire logic ref_clk_in,
    input wire logic [25:0] addr_in,
    input wire logic [5:0] cs_n_in,
    input wire logic oe_n_in,
    input wire logic restart_req_in,
    input wire logic [3:0] ack_delay_in,
    output logic [31:0] data_out,
    output logic ack_n_out,
    output logic restart_n_out
);
    logic [31:0] last_q = 32'h0;
    logic [3:0] wait_q = 4'h0;
    logic [3:0] hold_q = 4'h0;
    wire logic sel = !oe_n_in && !(&cs_n_in);
    // The acknowledge follows the select alone, since writes never lower the output enable.
    wire logic hit = !(&cs_n_in);

    function automatic logic [31:0] pat(input logic [25:0] a);
        return {a[15:0] ^ 16'h5a3c, ~a[15:0]};
    endfunction

    // A released bus shows the inverse of its last value, so a capture one cycle late cannot match by luck.
    assign data_out = sel ? pat(addr_in) : ~last_q;
    always @(posedge ref_clk_in) begin
        last_q <= data_out;
        wait_q <= hit ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
        ack_n_out <= !(hit && wait_q >= ack_delay_in);
        hold_q <= restart_req_in ? 4'h8 : hold_q - {3'h0, hold_q != 4'h0};
        restart_n_out <= hold_q == 4'h0;
    end
endmodule // ebcs_flash_model
`default_nettype wire

// ==== test/ebcs_top_assertions.sv ====
// Pin-timing checker for the external bus engine, bound into ebcs_top.
// Assumes mode inputs only change while the engine is idle.
`timescale 1ns/1ps
`default_nettype none
module ebcs_checker #(parameter integer ASYNC_WAIT = 4) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic req_ready_out,
    input wire logic req_write_in,
    input wire logic [3:0] req_be_in,
    input wire logic [2:0] req_cs_in,
    input wire logic [3:0] req_burst_len_in,
    input wire logic rsp_last_out,
    input wire logic [5:0] cs_burst_mode_in,
    input wire logic function_mux_control_in,
    input wire logic ack_mode_in,
    input wire logic [1:0] sdram_chip_select_n_in,
    input wire logic data_oe_out,
    input wire logic byte_strobe_lane3_msb_n_out,
    input wire logic byte_strobe_lane2_n_out,
    input wire logic byte_strobe_lane1_n_out,
    input wire logic byte_strobe_lane0_lsb_n_out,
    input wire logic output_enable_n_out,
    input wire logic read_write_out,
    input wire logic [5:0] chip_select_n_out,
    input wire logic chip_select4_oe_out,
    input wire logic burst_restart_n_in,
    input wire logic load_burst_address_n_out,
    input wire logic burst_clock_out
);
    // ************************************************************
    // Pin relations
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    localparam int AW2 = ASYNC_WAIT + 2;
    wire logic take = req_valid_in && req_ready_out;
    wire logic burst = !req_write_in && req_burst_len_in != 4'h0 && cs_burst_mode_in[req_cs_in];
    wire logic [3:0] strobes_n = {byte_strobe_lane3_msb_n_out, byte_strobe_lane2_n_out,
                                  byte_strobe_lane1_n_out, byte_strobe_lane0_lsb_n_out};

    a_read_pins: assert property (
        take && !req_write_in |=> read_write_out && strobes_n == 4'h0 && !data_oe_out)
        else $error("read pins wrong after take");
    a_write_pins: assert property (
        take && req_write_in |=> !read_write_out && data_oe_out && strobes_n == ~$past(req_be_in))
        else $error("write pins or strobes wrong");
    a_data_dir: assert property (data_oe_out |-> !read_write_out)
        else $error("data driven outside a write");
    a_read_oe: assert property (
        take && !req_write_in && !burst && !ack_mode_in |=> !output_enable_n_out[*5] ##1 rsp_last_out)
        else $error("output enable not held through async read");
    a_write_end: assert property (take && req_write_in && !ack_mode_in |-> ##AW2 rsp_last_out)
        else $error("write did not end on time");
    a_cs_assert: assert property (take |-> ##2 (!chip_select_n_out[$past(req_cs_in, 2)] ||
        (!function_mux_control_in && $past(req_cs_in, 2) inside {3'd2, 3'd3})))
        else $error("selected chip select not low");
    a_sdram_pass: assert property (
        (!function_mux_control_in)[*3] |-> chip_select_n_out[3:2] == $past(sdram_chip_select_n_in))
        else $error("sdram selects not passed to pins");
    a_ack_pin: assert property (
        (req_ready_out && $stable(ack_mode_in))[*3] |-> chip_select4_oe_out == !ack_mode_in)
        else $error("select 4 pin direction wrong");
    a_async_quiet: assert property (
        take && !burst |-> ##2 (!burst_clock_out && load_burst_address_n_out)[*3])
        else $error("burst pins moved on async access");
    a_lba_start: assert property (
        take && burst |=> !load_burst_address_n_out ##[1:12] $rose(burst_clock_out))
        else $error("burst start strobe or clock missing");
    a_restart_lba: assert property (
        $fell(burst_restart_n_in) && !req_ready_out |-> ##[1:12] !load_burst_address_n_out)
        else $error("restart did not reload burst address");
    c_burst: cover property (take && burst);
    c_restart: cover property ($fell(burst_restart_n_in) && !req_ready_out);
    c_ack: cover property (take && ack_mode_in);
endmodule // ebcs_checker
bind ebcs_top ebcs_checker #(.ASYNC_WAIT(ASYNC_WAIT)) i_ebcs_checker (.ref_clk_in, .rst_in, .req_valid_in,
    .req_ready_out, .req_write_in, .req_be_in, .req_cs_in, .req_burst_len_in, .rsp_last_out, .cs_burst_mode_in,
    .function_mux_control_in, .ack_mode_in, .sdram_chip_select_n_in, .data_oe_out, .byte_strobe_lane3_msb_n_out,
    .byte_strobe_lane2_n_out, .byte_strobe_lane1_n_out, .byte_strobe_lane0_lsb_n_out, .output_enable_n_out,
    .read_write_out, .chip_select_n_out, .chip_select4_oe_out, .burst_restart_n_in, .load_burst_address_n_out,
    .burst_clock_out);
`default_nettype wire

// ==== test/test_ebcs_top.sv ====
// Self-checking bench for the external bus engine and its far-side memory model.
// Assumes default timing parameters; restart is only requested in mid-burst.
`timescale 1ns/1ps
`default_nettype none
module test_ebcs_top;
    logic ref_clk_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0, function_mux_control_in = 0;
    logic ack_mode_in = 0, restart_req = 0, req_ready_out, rsp_valid_out, rsp_last_out, data_oe_out;
    logic byte_strobe_lane3_msb_n_out, byte_strobe_lane2_n_out, byte_strobe_lane1_n_out, byte_strobe_lane0_lsb_n_out;
    logic output_enable_n_out, read_write_out, chip_select4_oe_out, load_burst_address_n_out, burst_clock_out;
    logic burst_restart_n_in, ack_n;
    logic [25:0] req_addr_in = 0, address_out;
    logic [31:0] req_wdata_in = 0, rsp_rdata_out, data_out, data_in;
    logic [3:0] req_be_in = 0, req_burst_len_in = 0, ack_delay = 4'h3;
    logic [2:0] req_cs_in = 0;
    logic [5:0] cs_burst_mode_in = 6'h02, chip_select_n_out;
    logic [1:0] sdram_chip_select_n_in = 2'h3;
    logic [15:0] lfsr = 16'ha809, r;
    logic [31:0] exp_q[$];
    int mismatches = 0, n_tests = 0, i;
    // The select-4 pin is shared: the engine drives it unless it listens for the acknowledge.
    wire logic chip_select4_pin_in = chip_select4_oe_out ? chip_select_n_out[4] : ack_n;

    ebcs_top i_ebcs_top (.ref_clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_write_in, .req_addr_in,
        .req_wdata_in, .req_be_in, .req_cs_in, .req_burst_len_in, .rsp_valid_out, .rsp_rdata_out, .rsp_last_out,
        .cs_burst_mode_in, .function_mux_control_in, .ack_mode_in, .sdram_chip_select_n_in, .address_out, .data_out,
        .data_oe_out, .data_in, .byte_strobe_lane3_msb_n_out, .byte_strobe_lane2_n_out, .byte_strobe_lane1_n_out,
        .byte_strobe_lane0_lsb_n_out, .output_enable_n_out, .read_write_out, .chip_select_n_out, .chip_select4_oe_out,
        .chip_select4_pin_in, .burst_restart_n_in, .load_burst_address_n_out, .burst_clock_out);
    ebcs_flash_model i_ebcs_flash_model (.ref_clk_in(ref_clk_in), .addr_in(address_out), .cs_n_in(chip_select_n_out),
        .oe_n_in(output_enable_n_out), .restart_req_in(restart_req), .ack_delay_in(ack_delay), .data_out(data_in),
        .ack_n_out(ack_n), .restart_n_out(burst_restart_n_in));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [31:0] pat(input logic [25:0] a);
        return {a[15:0] ^ 16'h5a3c, ~a[15:0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic access(input logic wr, input logic [2:0] cs, input logic [3:0] len, input logic [25:0] a);
        int n;
        @(posedge ref_clk_in) #1;
        {req_valid_in, req_write_in, req_cs_in, req_burst_len_in, req_addr_in} = {1'b1, wr, cs, len, a};
        req_wdata_in = {rnd(), rnd()};
        req_be_in = lfsr[3:0];
        if (wr) exp_q.push_back(req_wdata_in);
        else for (n = 0; n < ((len == 4'h0 || !cs_burst_mode_in[cs]) ? 1 : int'(len)); n++)
            exp_q.push_back(pat(a + 26'(n)));
        n = 0;
        do @(posedge ref_clk_in); while (req_ready_out !== 1'b1 && ++n < 300);
        #1 req_valid_in = 0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do @(posedge ref_clk_in); while (!(req_ready_out === 1'b1 && exp_q.size() == 0) && ++n < 500);
        #1;
    endtask

    // ************************************************************
    // Stimulus and scoreboard
    // ************************************************************
    initial forever #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (rsp_valid_out === 1'b1 || rsp_last_out === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected response", 32'h1, 32'h0);
            else if (rsp_valid_out === 1'b1) check("read data", rsp_rdata_out, exp_q.pop_front());
            else check("write data", data_out, exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        #1 rst_in = 0;
        @(posedge ref_clk_in) #1;
        check("idle pins", {16'h0, req_ready_out, chip_select_n_out, byte_strobe_lane3_msb_n_out,
            byte_strobe_lane2_n_out, byte_strobe_lane1_n_out, byte_strobe_lane0_lsb_n_out, output_enable_n_out,
            read_write_out, data_oe_out, burst_clock_out, chip_select4_oe_out}, 32'hfff9);
        for (i = 0; i < 24; i++) begin
            r = rnd();
            if (i == 12) begin
                wait_idle();
                function_mux_control_in = 1;
            end
            sdram_chip_select_n_in = r[15:14];
            access(r[0], i < 12 ? {r[2], 1'b0, r[1]} : r[3:1] % 3'd6, 4'h0, {r, r[9:0]});
        end
        wait_idle();
        ack_mode_in = 1;
        for (i = 0; i < 4; i++) begin
            wait_idle();
            ack_delay = 4'(1 + 4 * i);
            access(i[0], 3'd0, 4'h0, {lfsr, 10'h3});
        end
        wait_idle();
        ack_mode_in = 0;
        access(1'b1, 3'd1, 4'h4, {lfsr, 10'h11});
        access(1'b0, 3'd1, 4'h1, {lfsr, 10'h3fe});
        access(1'b0, 3'd1, 4'hf, {lfsr, 10'h3f8});
        access(1'b0, 3'd1, 4'h6, {lfsr, 10'h40});
        repeat (30) @(posedge ref_clk_in);
        #1 restart_req = 1;
        @(posedge ref_clk_in) #1 restart_req = 0;
        wait_idle();
        check("responses left over", 32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule // test_ebcs_top
`default_nettype wire
